//--- hdl/i2c_dma_irq_control.sv
`timescale 1ns/1ps
`include "i2c_ctl_cfg.svh"
module i2c_dma_irq_control
  import i2c_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] tx_fifo_count,
  input wire logic tx_fifo_full,
  input wire logic tx_fifo_wr,
  input wire logic [9:0] tx_threshold,
  input wire logic [10:0] rx_fifo_count,
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_rd,
  input wire logic [9:0] rx_threshold,
  input wire logic slave_read_start,
  input wire logic slave_read_active,
  input wire logic slave_write_start,
  input wire logic master_done,
  input wire logic slave_done,
  input wire logic arbitration_lost,
  input wire logic bus_error_flag,
  input wire logic master_done_no_stop,
  input wire logic [31:0] interrupt_clear_register,
  input wire logic master_mode,
  input wire logic dma_tx_enable,
  input wire logic [10:0] tx_bytes_left,
  input wire logic dma_tx_done,
  input wire logic scl_in,
  output logic scl_oe,
  output logic tx_flush_bit,
  output logic dma_tx_single,
  output logic dma_tx_burst,
  output logic irq
);
  logic [2:0] tx_dest_burst_len_q;
  logic burst_mode_q;
  logic [`RATE_HI:0] rate_count_value_q;
  word_t mask_q;
  word_t sticky_q;
  word_t raw;
  logic tx_fifo_empty_flag_q;
  logic tx_fifo_low_flag_q;
  logic tx_fifo_full_flag_q;
  logic rx_fifo_empty_flag_q;
  logic rx_fifo_high_flag_q;
  logic slave_read_starved_q;
  logic wr_take;
  logic rd_setup;
  logic scl_level;
  logic scl_low;
  len_t free_space;
  len_t burst_bytes;
  word_t set_ev;

  // Burst size code n means 2^(n+1) bytes, code 0 a single byte.
  function automatic len_t burst_of(input logic [2:0] code);
    len_t r;
    r = 11'h001;
    if (code != 3'h0)
    begin
      r = len_t'(11'h002 << code);
    end
    return r;
  endfunction : burst_of

  // One address decode serves both the read path and the write path.
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] s;
    s = 3'h0;
    if (a == `OFF_DMA_CFG)
    begin
      s = 3'h1;
    end
    else if (a == `OFF_RATE)
    begin
      s = 3'h2;
    end
    else if (a == `OFF_MASK)
    begin
      s = 3'h3;
    end
    else if (a == `OFF_RAW)
    begin
      s = 3'h4;
    end
    return s;
  endfunction : reg_sel

  // A write commits on the access edge, when pready is already high.
  assign wr_take = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  // Register updates; the raw status word ignores writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_dest_burst_len_q <= 3'h0;
      burst_mode_q <= 1'b0;
      rate_count_value_q <= `RATE_RST;
      mask_q <= 32'h00000000;
    end
    else if (wr_take)
    begin
      if (reg_sel(paddr) == 3'h1)
      begin
        tx_dest_burst_len_q <= pwdata[`DMA_BLEN_HI:`DMA_BLEN_LO];
        burst_mode_q <= pwdata[`DMA_BURST_BIT];
      end
      else if (reg_sel(paddr) == 3'h2)
      begin
        rate_count_value_q <= pwdata[`RATE_HI:0];
      end
      else if (reg_sel(paddr) == 3'h3)
      begin
        mask_q <= pwdata & `MASK_BITS;
      end
    end
  end

  // Bus answer: ready one cycle after setup, so every access has no wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= rd_setup;
      pslverr <= rd_setup && (reg_sel(paddr) == 3'h0);
      prdata <= 32'h00000000;
      if (rd_setup && !pwrite)
      begin
        if (reg_sel(paddr) == 3'h1)
        begin
          prdata[`DMA_BLEN_HI:`DMA_BLEN_LO] <= tx_dest_burst_len_q;
          prdata[`DMA_BURST_BIT] <= burst_mode_q;
        end
        else if (reg_sel(paddr) == 3'h2)
        begin
          prdata[`RATE_HI:0] <= rate_count_value_q;
        end
        else if (reg_sel(paddr) == 3'h3)
        begin
          prdata <= mask_q;
        end
        else if (reg_sel(paddr) == 3'h4)
        begin
          prdata <= raw;
        end
      end
    end
  end

  // Level flags follow the FIFO state; the empty flags come up set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_fifo_empty_flag_q <= 1'b1;
      tx_fifo_low_flag_q <= 1'b1;
      tx_fifo_full_flag_q <= 1'b0;
      rx_fifo_empty_flag_q <= 1'b1;
      rx_fifo_high_flag_q <= 1'b0;
    end
    else
    begin
      tx_fifo_empty_flag_q <= (tx_fifo_count == 11'h000);
      tx_fifo_low_flag_q <= (tx_fifo_count <= {1'b0, tx_threshold});
      tx_fifo_full_flag_q <= tx_fifo_full;
      rx_fifo_empty_flag_q <= (rx_fifo_count == 11'h000);
      rx_fifo_high_flag_q <= (rx_fifo_count >= {1'b0, rx_threshold});
    end
  end

  // Starved is a level, dropped by a write or by the end of the read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slave_read_starved_q <= 1'b0;
    end
    else
    begin
      slave_read_starved_q <= slave_read_active && !tx_fifo_wr &&
        (tx_fifo_count == 11'h000);
    end
  end

  // Event inputs that latch into sticky bits.
  always_comb
  begin
    set_ev = 32'h00000000;
    set_ev[`B_TXOVR] = tx_fifo_wr && tx_fifo_full;
    set_ev[`B_RXFULL] = rx_fifo_full;
    set_ev[`B_SRREQ] = slave_read_start;
    set_ev[`B_SWREQ] = slave_write_start;
    set_ev[`B_MDONE] = master_done;
    set_ev[`B_SDONE] = slave_done;
    set_ev[`B_ARB] = arbitration_lost;
    set_ev[`B_BUS_ERROR_FLAG] = bus_error_flag;
    set_ev[`B_MDNS] = master_done_no_stop;
  end

  // Sticky bits: an event in the clearing cycle wins over the clear.
  // Receive full also drops on a FIFO read; slave read request on a write.
  generate
    for (genvar i = 0; i < 32; i++)
    begin : g_sticky
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sticky_q[i] <= 1'b0;
        end
        else if (set_ev[i])
        begin
          sticky_q[i] <= 1'b1;
        end
        else if (interrupt_clear_register[i] ||
          (i == `B_RXFULL && rx_fifo_rd) ||
          (i == `B_SRREQ && tx_fifo_wr))
        begin
          sticky_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Raw status word as software sees it.
  always_comb
  begin
    raw = sticky_q & `MASK_BITS;
    raw[`B_TXE] = tx_fifo_empty_flag_q;
    raw[`B_TXLOW] = tx_fifo_low_flag_q;
    raw[`B_TXFULL] = tx_fifo_full_flag_q;
    raw[`B_RXE] = rx_fifo_empty_flag_q;
    raw[`B_RXHIGH] = rx_fifo_high_flag_q;
    raw[`B_SRSTARVE] = slave_read_starved_q;
  end

  // Interrupt line is registered, so it trails the raw flags by a cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(raw & mask_q);
    end
  end

  // Stale data from an earlier transfer is dropped before the new read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_flush_bit <= 1'b0;
    end
    else
    begin
      tx_flush_bit <= slave_read_start;
    end
  end

  // Request sizing; the burst length matters only in burst mode.
  assign burst_bytes = burst_mode_q ? burst_of(tx_dest_burst_len_q) :
    11'h001;
  assign free_space = `TX_DEPTH - tx_fifo_count;

  // A request stays up until the DMA engine reports it done or the
  // enable drops. A burst is raised only when both the space and the
  // remaining bytes cover it; otherwise singles finish the transfer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_tx_single <= 1'b0;
      dma_tx_burst <= 1'b0;
    end
    else if (dma_tx_done || !dma_tx_enable)
    begin
      dma_tx_single <= 1'b0;
      dma_tx_burst <= 1'b0;
    end
    else if (!dma_tx_single && !dma_tx_burst &&
      tx_bytes_left != 11'h000)
    begin
      if (burst_mode_q && burst_bytes <= tx_bytes_left &&
        burst_bytes <= free_space)
      begin
        dma_tx_burst <= 1'b1;
      end
      else if (free_space != 11'h000)
      begin
        dma_tx_single <= 1'b1;
      end
    end
  end

  // Serial clock pin, sampled into this domain before use.
  pin_sync u_scl_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(scl_in),
    .sync_out(scl_level)
  );

  // Rate counter drives the clock only while acting as master.
  rate_gen u_rate
  (
    .pclk(pclk),
    .presetn(presetn),
    .run(master_mode),
    .rate_count_value(rate_count_value_q),
    .scl_level(scl_level),
    .scl_drive_low(scl_low)
  );

  // Open drain clock: enable means pull low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_oe <= 1'b0;
    end
    else
    begin
      scl_oe <= scl_low;
    end
  end
endmodule : i2c_dma_irq_control

//--- hdl/i2c_ctl_cfg.svh
`ifndef I2C_CTL_CFG_SVH
`define I2C_CTL_CFG_SVH
// Register byte offsets.
`define OFF_DMA_CFG 8'h24
`define OFF_RATE 8'h28
`define OFF_MASK 8'h2c
`define OFF_RAW 8'h30
// Request configuration fields.
`define DMA_BLEN_HI 10
`define DMA_BLEN_LO 8
`define DMA_BURST_BIT 11
// Rate counter field and reset value.
`define RATE_HI 15
`define RATE_RST 16'h0008
// Raw status bit positions, shared by the enable mask.
`define B_TXE 0
`define B_TXLOW 1
`define B_TXFULL 2
`define B_TXOVR 3
`define B_RXE 4
`define B_RXHIGH 5
`define B_RXFULL 6
`define B_SRREQ 16
`define B_SRSTARVE 17
`define B_SWREQ 18
`define B_MDONE 19
`define B_SDONE 20
`define B_ARB 24
`define B_BUS_ERROR_FLAG 25
`define B_MDNS 28
// Implemented mask bits and the reset of the raw status word.
`define MASK_BITS 32'h131f007f
`define RAW_RST 32'h00000013
// Transmit FIFO depth in bytes.
`define TX_DEPTH 11'h040
`endif

//--- hdl/i2c_ctl_pkg.sv
package i2c_ctl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [10:0] len_t;
  // Serial clock phases, Gray coded along high, low, stretch.
  typedef enum logic [1:0]
  {
    PH_HIGH = 2'b00,
    PH_LOW = 2'b01,
    PH_WAIT = 2'b11
  } scl_phase_e;
endpackage : i2c_ctl_pkg

//--- hdl/pin_sync.sv
`timescale 1ns/1ps
// Two stage synchroniser; only the second stage is visible outside.
module pin_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // The first stage feeds the second and nothing else.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync

//--- hdl/rate_gen.sv
`timescale 1ns/1ps
`include "i2c_ctl_cfg.svh"
// Master serial clock generator: each counted phase lasts rate_count_value plus one cycles.
module rate_gen
  import i2c_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [`RATE_HI:0] rate_count_value,
  input wire logic scl_level,
  output logic scl_drive_low
);
  scl_phase_e ph_q;
  logic [`RATE_HI:0] cnt_q;

  // A released line held low by a slave delays the start of the high phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q <= PH_HIGH;
      cnt_q <= '0;
      scl_drive_low <= 1'b0;
    end
    else if (!run)
    begin
      ph_q <= PH_HIGH;
      cnt_q <= '0;
      scl_drive_low <= 1'b0;
    end
    else
    begin
      case (ph_q)
        PH_HIGH:
        begin
          if (cnt_q >= rate_count_value)
          begin
            ph_q <= PH_LOW;
            cnt_q <= '0;
            scl_drive_low <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        PH_LOW:
        begin
          if (cnt_q >= rate_count_value)
          begin
            ph_q <= PH_WAIT;
            cnt_q <= '0;
            scl_drive_low <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        PH_WAIT:
        begin
          if (scl_level)
          begin
            ph_q <= PH_HIGH;
          end
        end
        default:
        begin
          ph_q <= PH_HIGH;
        end
      endcase
    end
  end
endmodule : rate_gen

//--- verif/far_side_model.sv
`timescale 1ns/1ps
// Far side: a DMA engine serving requests, and a pulled-up clock line.
module far_side_model
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic req,
  input wire logic scl_oe,
  output logic done,
  output logic scl_in
);
  // Once the pin is released the pull-up brings the line high.
  assign scl_in = !scl_oe;
  // Serve after one or six cycles, acking only a request still standing.
  initial
  begin
    done = 1'b0;
    forever
    begin
      @(posedge pclk);
      if (req)
      begin
        repeat (slow ? 6 : 1) @(posedge pclk);
        done <= req;
        @(posedge pclk);
        done <= 1'b0;
      end
    end
  end
endmodule : far_side_model

//--- verif/i2c_dma_irq_control_properties.sv
`timescale 1ns/1ps
`include "i2c_ctl_cfg.svh"
module i2c_dma_irq_control_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [10:0] tx_bytes_left,
  input wire logic slave_read_start,
  input wire logic master_mode,
  input wire logic scl_oe,
  input wire logic tx_flush_bit,
  input wire logic dma_tx_enable,
  input wire logic dma_tx_single,
  input wire logic dma_tx_burst
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] burst_need_q;

  // Shadow of the programmed burst size, taken from bus writes, so that a
  // burst can be held against the bytes still to move.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      burst_need_q <= 11'h001;
    end
    else if (psel && penable && pready && pwrite && paddr == `OFF_DMA_CFG)
    begin
      burst_need_q <= (pwdata[`DMA_BLEN_HI:`DMA_BLEN_LO] == 3'h0) ? 11'h001 :
        (11'h002 << pwdata[`DMA_BLEN_HI:`DMA_BLEN_LO]);
    end
  end

  // Bus answers, flush, request style and the master clock.
  apb_answer_a:
    assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  err_ready_a:
    assert property (pslverr |-> pready ##1 !pready)
    else $error("error without a one cycle answer");
  flush_follows_a:
    assert property (slave_read_start |=> tx_flush_bit)
    else $error("no flush after slave read start");
  flush_cause_a:
    assert property (tx_flush_bit |-> $past(slave_read_start))
    else $error("flush without cause");
  one_kind_a:
    assert property (!(dma_tx_single && dma_tx_burst))
    else $error("single and burst together");
  burst_len_a:
    assert property ($rose(dma_tx_burst) |->
      $past(tx_bytes_left) >= burst_need_q)
    else $error("burst longer than what is left");
  req_enable_a:
    assert property ($rose(dma_tx_single) |-> $past(dma_tx_enable))
    else $error("single request without enable");
  scl_idle_a:
    assert property (!master_mode [*3] |-> !scl_oe)
    else $error("clock driven outside master mode");
  cover property ($rose(dma_tx_burst));
  cover property (pslverr);
  cover property ($rose(scl_oe));
endmodule : i2c_dma_irq_control_properties

bind i2c_dma_irq_control i2c_dma_irq_control_properties u_props
(
  .pclk, .presetn, .psel, .penable, .pready, .pwrite, .paddr, .pwdata,
  .pslverr, .tx_bytes_left,
  .slave_read_start, .master_mode, .scl_oe, .tx_flush_bit,
  .dma_tx_enable, .dma_tx_single, .dma_tx_burst
);

//--- verif/test_i2c_dma_irq_control.sv
`timescale 1ns/1ps
module test_i2c_dma_irq_control
  import i2c_ctl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic txf = 0, wr = 0, rxf = 0, rdp = 0, act = 0, mm = 0, en = 0;
  logic slow = 0, pready, pslverr, scl_in, scl_oe, sgl, bst, irq, done, fl;
  logic [9:0] tth = '0, rth = 10'h1;
  logic [7:0] paddr = '0;
  logic [10:0] txc = '0, rxc = '0, left = '0;
  word_t pwdata = '0, ev = '0, cl = '0, prdata, rv;
  logic [32:0] exp_q[$];
  int n_mismatch = 0, tests_run = 0, k;
  int evb[7] = '{16, 18, 19, 20, 24, 25, 28};
  int dm[6] = '{32'h01014000, 32'h01014700, 32'h01003900,
    32'h02014800, 32'h02014900, 32'h01014f00};
  i2c_dma_irq_control u_i2c_dma_irq_control
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_fifo_count(txc), .tx_fifo_full(txf),
    .tx_fifo_wr(wr), .tx_threshold(tth), .rx_fifo_count(rxc),
    .rx_fifo_full(rxf), .rx_fifo_rd(rdp), .rx_threshold(rth),
    .slave_read_start(ev[16]), .slave_read_active(act),
    .slave_write_start(ev[18]), .master_done(ev[19]),
    .slave_done(ev[20]), .arbitration_lost(ev[24]),
    .bus_error_flag(ev[25]), .master_done_no_stop(ev[28]),
    .interrupt_clear_register(cl), .master_mode(mm),
    .dma_tx_enable(en), .tx_bytes_left(left), .dma_tx_done(done),
    .scl_in, .scl_oe, .tx_flush_bit(fl), .dma_tx_single(sgl),
    .dma_tx_burst(bst), .irq
  );
  far_side_model u_far_side_model
  (
    .pclk, .slow, .req(sgl | bst), .scl_oe, .done, .scl_in
  );
  // Free running bus clock.
  always #12.5 pclk = ~pclk;
  task automatic check(input string n, input logic [32:0] s,
    input logic [32:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // An idle edge follows each transfer so psel never toggles twice.
  task automatic apb(input logic w, input logic [7:0] a, input word_t d,
    input logic [32:0] e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (!pready);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Every read answer is matched with the oldest expectation.
  always @(posedge pclk)
    if (pready && !pwrite)
      check("read", {pslverr, prdata}, exp_q.pop_front());
  // The run needs far fewer cycles than this.
  initial
  begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(4));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h24, 0, 0);
    apb(0, 8'h28, 0, 33'h8);
    apb(1, 8'h30, '1, 0);
    apb(0, 8'h30, 0, 33'h13);
    apb(0, 8'h40, 0, 33'h100000000);
    rv = $urandom;
    apb(1, 8'h28, rv, 0);
    apb(0, 8'h28, 0, {17'h0, rv[15:0]});
    apb(0, 8'h2c, 0, 0);
    apb(1, 8'h2c, '1, 0);
    apb(0, 8'h2c, 0, 33'h131f007f);
    txc <= 11'd64;
    txf <= 1;
    rxc <= 11'd5;
    repeat (2) @(posedge pclk);
    apb(0, 8'h30, 0, 33'h24);
    // Thresholds moved to the counts: low holds at equal, high drops below.
    tth <= 10'd64;
    rth <= 10'd6;
    repeat (2) @(posedge pclk);
    apb(0, 8'h30, 0, 33'h6);
    tth <= '0;
    rth <= 10'h1;
    wr <= 1;
    @(posedge pclk);
    wr <= 0;
    apb(0, 8'h30, 0, 33'h2c);
    cl <= 32'h8;
    @(posedge pclk);
    cl <= 0;
    apb(0, 8'h30, 0, 33'h24);
    txc <= 0;
    txf <= 0;
    rxc <= 0;
    rxf <= 1;
    @(posedge pclk);
    rxf <= 0;
    apb(0, 8'h30, 0, 33'h53);
    rdp <= 1;
    @(posedge pclk);
    rdp <= 0;
    apb(0, 8'h30, 0, 33'h13);
    act <= 1;
    @(posedge pclk);
    apb(0, 8'h30, 0, 33'h20013);
    wr <= 1;
    txc <= 11'd1;
    @(posedge pclk);
    wr <= 0;
    apb(0, 8'h30, 0, 33'h10);
    txc <= 0;
    act <= 0;
    @(posedge pclk);
    apb(0, 8'h30, 0, 33'h13);
    // Each event sticks until its own clear strobe.
    foreach (evb[i])
    begin
      ev[evb[i]] <= 1;
      @(posedge pclk);
      ev <= '0;
      @(posedge pclk);
      check("flush", fl, 33'(evb[i] == 16));
      apb(0, 8'h30, 0, 33'h13 | (33'h1 << evb[i]));
      cl[evb[i]] <= 1;
      @(posedge pclk);
      cl <= '0;
      apb(0, 8'h30, 0, 33'h13);
    end
    apb(1, 8'h2c, 0, 0);
    @(posedge pclk);
    check("irq", irq, 0);
    apb(1, 8'h2c, 32'h10, 0);
    @(posedge pclk);
    check("irq", irq, 1);
    // Request style per setting; the far side answers fast and slow.
    foreach (dm[i])
    begin
      apb(1, 8'h24, dm[i][11:0], 0);
      left <= dm[i][22:12];
      slow <= i[0];
      en <= 1;
      for (k = 0; k < 40 && !(sgl || bst); k++)
        @(posedge pclk);
      check("dma", {bst, sgl}, dm[i][25:24]);
      for (k = 0; k < 40 && (sgl || bst); k++)
        @(posedge pclk);
      en <= 0;
      repeat (2) @(posedge pclk);
    end
    apb(1, 8'h28, 2, 0);
    mm <= 1;
    for (k = 0; k < 40 && !scl_oe; k++)
      @(posedge pclk);
    for (k = 0; k < 40 && scl_oe; k++)
      @(posedge pclk);
    check("low", 33'(k), 3);
    mm <= 0;
    repeat (4) @(posedge pclk);
    check("idle", scl_oe, 0);
    end_of_test();
  end
endmodule : test_i2c_dma_irq_control
